// ==== src/tapc_top.sv ====
// thermal alarm pin control: limits, shared pin, timer, fan override
// Function
// - timer monitoring only when timer enable set
// - pin alarm role needs function select and enable
// - per channel bits let channel drive pin
// - external pull low is timed too
// - all channel bits clear: never drive pin
// - override on, fans running: full duty
// - fans stopped at assertion stay stopped
// - override off: duty left as set
// - mask bit suppresses timer limit alert
// - zero limit alerts on first assertion
// - drive low when above limit by quarter degree
// - stay low until temp at or below
// - hold low at least one monitoring cycle
// - three limit registers at consecutive addresses
// - lowest limit code disables that channel
// - timer enable clear disables pin alarm function
// - low frequency choices plus one high
// - four speed inputs, three drives
// - timer accumulates, clears on read, saturates
// - first assertion marks one, then steps
// - timer above limit sets flag, alerts
`timescale 1ns/100ps
module tapc_top import tapc_pkg::*; #(
    parameter int unsigned TIMER_LSB_CYC = TMR_LSB_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port from the serial bus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // temperature readings
    input wire tapc_temp_t [2:0] temps,
    input wire logic mon_upd,
    input wire logic twos_mode,
    // fan settings from the speed control loop
    input wire logic [2:0][7:0] duty_req,
    // shared alarm pin, open drain
    input wire logic alarm_pin_i,
    output logic alarm_pin_o,
    output logic alarm_pin_oe_b,
    // results
    output logic [2:0][7:0] duty_eff,
    output logic [2:0] fan_drive,
    output logic fourth_speed_sense_input,
    output logic smb_alert_req,
    output logic timer_limit_flag
);
    tapc_state_t s, nxt; // state and next state
    logic role_on; // pin serves the alarm role
    logic asrt; // pin seen asserted
    logic rise; // first cycle of an assertion
    logic tmr_clr; // timer read strobe
    logic [7:0] tmr_val; // timer reading
    logic [7:0] rd_val; // read mux output
    logic [2:0] dis; // channel disabled by its limit
    logic [2:0] hot; // channel above its limit
    logic [2:0] full_speed_override; // fan forced to full duty

    // pin role and assertion from registered values, timer read strobe straight from the bus inputs
    always_comb begin
        // alarm role needs the select field and the enable bit
        role_on = s.regs.cfg3[CFG3_TMR_EN]
            && (s.regs.cfg4[1:0] == PINF_ALARM);
        // low on the synchronised pin, whoever pulls it
        asrt = role_on && !s.pin_sync[1];
        rise = asrt && !s.asrt_d;
        tmr_clr = reg_rd && (reg_addr == OFS_TMR);
    end

    // per channel limit compare
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // flip the sign bit so twos complement compares as unsigned
            dis[i] = (s.regs.lim[i] ^ (twos_mode ? TEMP_SIGN : 8'h00))
                == 8'h00;
            // any fraction above the limit means a quarter degree over
            hot[i] = {temps[i].whole ^ (twos_mode ? TEMP_SIGN : 8'h00),
                temps[i].frac}
                > {s.regs.lim[i] ^ (twos_mode ? TEMP_SIGN : 8'h00),
                2'b00};
        end
    end

    // read mux
    always_comb begin
        case (reg_addr)
            OFS_LIM_R1: begin
                rd_val = s.regs.lim[0];
            end
            OFS_LIM_LO: begin
                rd_val = s.regs.lim[1];
            end
            OFS_LIM_R2: begin
                rd_val = s.regs.lim[2];
            end
            OFS_MASK2: begin
                rd_val = s.regs.mask2;
            end
            OFS_CFG3: begin
                rd_val = s.regs.cfg3;
            end
            OFS_TMR: begin
                rd_val = tmr_val;
            end
            OFS_TLIM: begin
                rd_val = s.regs.tlim;
            end
            OFS_CFG5: begin
                rd_val = s.regs.cfg5;
            end
            OFS_CFG4: begin
                rd_val = s.regs.cfg4;
            end
            OFS_STAT2: begin
                rd_val = {2'b00, s.flag, 5'h00};
            end
            OFS_FREQ: begin
                rd_val = s.regs.freq;
            end
            default: begin
                rd_val = 8'h00; // unmapped reads zero
            end
        endcase
    end

    // next state
    always_comb begin
        nxt = s;
        // two flop synchroniser on the pin
        nxt.pin_sync = {s.pin_sync[0], alarm_pin_i};
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                OFS_LIM_R1: begin
                    nxt.regs.lim[0] = reg_wdata;
                end
                OFS_LIM_LO: begin
                    nxt.regs.lim[1] = reg_wdata;
                end
                OFS_LIM_R2: begin
                    nxt.regs.lim[2] = reg_wdata;
                end
                OFS_MASK2: begin
                    nxt.regs.mask2 = reg_wdata;
                end
                OFS_CFG3: begin
                    nxt.regs.cfg3 = reg_wdata;
                end
                OFS_TLIM: begin
                    nxt.regs.tlim = reg_wdata;
                end
                OFS_CFG5: begin
                    nxt.regs.cfg5 = reg_wdata;
                end
                OFS_CFG4: begin
                    nxt.regs.cfg4 = reg_wdata;
                end
                OFS_FREQ: begin
                    nxt.regs.freq = reg_wdata;
                end
                default: begin
                    nxt.regs = s.regs; // read only or unmapped
                end
            endcase
        end
        // read data held until the next read
        if (reg_rd) begin
            nxt.rdata = rd_val;
        end
        // channels re-evaluated once per monitoring cycle only
        if (mon_upd) begin
            nxt.over = hot & ~dis;
        end
        // drive low only for channels enabled as sources
        nxt.drive = role_on
            && |(s.over & s.regs.cfg5[CFG5_BIDIR_LSB +: 3]);
        // fan override on assertion
        nxt.asrt_d = asrt;
        for (int i = 0; i < 3; i++) begin
            // running state caught at the start of the assertion
            if (rise) begin
                nxt.fan_run[i] = duty_req[i] != 8'h00;
            end
            full_speed_override[i] = asrt && s.regs.cfg3[CFG3_FULL_SPEED_OVERRIDE]
                && (rise ? duty_req[i] != 8'h00 : s.fan_run[i]);
            nxt.duty[i] = full_speed_override[i] ? DUTY_FULL : duty_req[i];
        end
        // status read clears the flag, a new excess wins
        if (reg_rd && reg_addr == OFS_STAT2) begin
            nxt.flag = 1'b0;
        end
        if (tmr_val > s.regs.tlim) begin
            nxt.flag = 1'b1;
        end
        nxt.alert = nxt.flag && !nxt.regs.mask2[MASK2_TLIM];
        // pin handed to speed sensing when so selected
        nxt.spd4 = (s.regs.cfg4[1:0] == PINF_SPD4) ? s.pin_sync[1] : 1'b1;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s <= '0;
            s.regs <= RST_REGS; // timer off, pin in speed sense role
            s.pin_sync <= 2'b11; // idle line is high
            s.spd4 <= 1'b1;
        end else begin
            s <= nxt;
        end
    end

    // cumulative assertion timer
    tapc_timer #(
        .LSB_CYC(TIMER_LSB_CYC)
    ) i_tapc_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(asrt),
        .clr(tmr_clr),
        .val(tmr_val)
    );

    // three drives, the third also feeds a fourth fan
    generate
        for (genvar g = 0; g < 3; g++) begin : g_fan
            tapc_pwm i_tapc_pwm (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .duty(s.duty[g]),
                .freq_sel(s.regs.freq[2:0]),
                .pwm(fan_drive[g])
            );
        end
    endgenerate

    // outputs
    assign reg_rdata = s.rdata;
    assign alarm_pin_o = 1'b0; // open drain, only ever pulls low
    assign alarm_pin_oe_b = !s.drive;
    assign duty_eff = s.duty;
    assign fourth_speed_sense_input = s.spd4;
    assign smb_alert_req = s.alert;
    assign timer_limit_flag = s.flag;

    // all checks below run on the system clock, off during reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // pin role and drive checks
    tmr_gate_a: assert property (!s.regs.cfg3[CFG3_TMR_EN] |-> !asrt)
        else $error("timer ran while disabled");
    pin_role_a: assert property (s.drive |-> $past(role_on))
        else $error("pin driven outside alarm role");
    chan_src_a: assert property (s.drive |->
        $past(|(s.over & s.regs.cfg5[CFG5_BIDIR_LSB +: 3])))
        else $error("pin driven without an enabled hot channel");
    ext_time_a: assert property (role_on && !s.pin_sync[1] && !s.drive
        |=> tmr_val != 8'h00)
        else $error("external assertion not timed");
    no_drive_a: assert property (s.regs.cfg5[7:5] == 3'b000 |=> alarm_pin_oe_b)
        else $error("pin driven with no source channel");
    spd4_sel_a: assert property (s.regs.cfg4[1:0] != PINF_SPD4
        |=> fourth_speed_sense_input)
        else $error("speed sense output moved outside its role");
    // fan override checks
    full_speed_override_a: assert property (asrt && s.asrt_d && s.regs.cfg3[CFG3_FULL_SPEED_OVERRIDE]
        && s.fan_run[0] |=> duty_eff[0] == DUTY_FULL)
        else $error("override did not force full duty");
    stopped_a: assert property (asrt && s.asrt_d && !s.fan_run[1]
        |=> duty_eff[1] == $past(duty_req[1]))
        else $error("stopped fan was forced on");
    no_full_speed_override_a: assert property (!s.regs.cfg3[CFG3_FULL_SPEED_OVERRIDE]
        |=> duty_eff == $past(duty_req))
        else $error("duty changed with override off");
    // timer limit flag and alert checks
    mask_a: assert property (s.regs.mask2[MASK2_TLIM] |-> !smb_alert_req)
        else $error("masked alert was raised");
    lim_zero_a: assert property (s.regs.tlim == 8'h00 && tmr_val != 8'h00
        |=> timer_limit_flag)
        else $error("zero limit did not flag first assertion");
    flag_set_a: assert property (tmr_val > s.regs.tlim |=> timer_limit_flag)
        else $error("timer above limit did not set the flag");
    alert_on_a: assert property (timer_limit_flag && !s.regs.mask2[MASK2_TLIM]
        |-> smb_alert_req)
        else $error("unmasked flag raised no alert");
    // channel compare checks
    over_hold_a: assert property ($changed(s.over) |-> $past(mon_upd))
        else $error("channel state changed between monitoring cycles");
    lim_dis_a: assert property (mon_upd && dis[0] |=> !s.over[0])
        else $error("disabled channel went over");
    hot_set_a: assert property (mon_upd && hot[2] && !dis[2] |=> s.over[2])
        else $error("hot channel not marked");

    // main scenarios reached
    drive_c: cover property ($rose(s.drive));
    flag_c: cover property ($rose(timer_limit_flag));
    full_speed_override_c: cover property (asrt ##1 duty_eff[0] == DUTY_FULL);
    spd4_c: cover property (s.regs.cfg4[1:0] == PINF_SPD4 ##1 !fourth_speed_sense_input);
endmodule // tapc_top

// ==== src/tapc_pkg.sv ====
// package: constants and carrier types of the thermal alarm pin block
package tapc_pkg;
    // register offsets
    localparam logic [7:0] OFS_LIM_R1 = 8'h6A;
    localparam logic [7:0] OFS_LIM_LO = 8'h6B;
    localparam logic [7:0] OFS_LIM_R2 = 8'h6C;
    localparam logic [7:0] OFS_MASK2 = 8'h75;
    localparam logic [7:0] OFS_CFG3 = 8'h78;
    localparam logic [7:0] OFS_TMR = 8'h79;
    localparam logic [7:0] OFS_TLIM = 8'h7A;
    localparam logic [7:0] OFS_CFG5 = 8'h7C;
    localparam logic [7:0] OFS_CFG4 = 8'h7D;
    localparam logic [7:0] OFS_STAT2 = 8'h42;
    localparam logic [7:0] OFS_FREQ = 8'h5F;
    // field positions
    localparam int CFG3_TMR_EN = 1;
    localparam int CFG3_FULL_SPEED_OVERRIDE = 2;
    localparam int CFG5_BIDIR_LSB = 5;
    localparam int MASK2_TLIM = 5;
    localparam int STAT2_TLIM = 5;
    localparam logic [1:0] PINF_ALARM = 2'b00;
    localparam logic [1:0] PINF_SPD4 = 2'b01;
    // codes
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] TEMP_SIGN = 8'h80;
    localparam logic [2:0] PWM_HIGH_SEL = 3'h7;
    localparam logic [15:0] PWM_LOW_BASE = 16'h0100;
    // timing: one timer step is 22.76 ms
    localparam int CLK_PERIOD_NS = 4;
    localparam int TMR_LSB_NS = 22760000;
    localparam int TMR_LSB_CYC = TMR_LSB_NS / CLK_PERIOD_NS;
    localparam int TMR_PRE_W = 23;
    // software registers
    typedef struct packed {
        logic [2:0][7:0] lim; // critical limits, remote1 local remote2
        logic [7:0] mask2;
        logic [7:0] cfg3;
        logic [7:0] cfg4;
        logic [7:0] cfg5;
        logic [7:0] tlim;
        logic [7:0] freq;
    } tapc_regs_t;
    // reset values
    localparam logic [7:0] RST_LIM = 8'h64;
    localparam logic [7:0] RST_CFG4 = 8'h01;
    localparam logic [7:0] RST_FREQ = 8'h04;
    localparam tapc_regs_t RST_REGS = '{lim: {RST_LIM, RST_LIM, RST_LIM},
        mask2: 8'h00, cfg3: 8'h00, cfg4: RST_CFG4, cfg5: 8'h00, tlim: 8'h00,
        freq: RST_FREQ};
    // one temperature reading, quarter degree fraction
    typedef struct packed {
        logic [7:0] whole;
        logic [1:0] frac;
    } tapc_temp_t;
    // main state
    typedef struct packed {
        tapc_regs_t regs;
        logic [7:0] rdata;
        logic [1:0] pin_sync;
        logic [2:0] over;
        logic drive;
        logic asrt_d;
        logic [2:0] fan_run;
        logic [2:0][7:0] duty;
        logic flag;
        logic alert;
        logic spd4;
    } tapc_state_t;
    // timer state
    typedef struct packed {
        logic [TMR_PRE_W-1:0] pre;
        logic [7:0] units;
        logic seen;
        logic [7:0] val;
    } tapc_tmr_t;
    // pwm state
    typedef struct packed {
        logic [15:0] pre;
        logic [7:0] cnt;
        logic out;
    } tapc_pwm_t;
endpackage

// ==== src/tapc_timer.sv ====
// cumulative alarm assertion timer, clear on read, saturating
`timescale 1ns/100ps
module tapc_timer import tapc_pkg::*; #(
    parameter int unsigned LSB_CYC = TMR_LSB_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // control
    input wire logic run,
    input wire logic clr,
    // timer reading
    output logic [7:0] val
);
    tapc_tmr_t s, nxt; // state and next state

    // clear first, then accumulate so an assertion is never lost
    always_comb begin
        nxt = s;
        if (clr) begin
            nxt.units = 8'h00;
            nxt.seen = 1'b0;
            nxt.pre = '0;
        end
        if (run) begin
            nxt.seen = 1'b1;
            if (s.pre == TMR_PRE_W'(LSB_CYC - 1) && !clr) begin
                nxt.pre = '0;
                if (s.units != 8'hFF) begin
                    nxt.units = s.units + 8'h01;
                end
            end else if (!clr) begin
                nxt.pre = s.pre + 1'b1;
            end
        end
        // first assertion shows 1, later the step count
        nxt.val = !nxt.seen ? 8'h00 : (nxt.units == 8'h00 ? 8'h01 : nxt.units);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign val = s.val;

    sat_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s.units == 8'hFF && !clr |=> s.units == 8'hFF)
        else $error("timer left full scale without a clear");
    first_mark_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        run |=> val != 8'h00)
        else $error("assertion not marked in timer");
    clr_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clr && run |=> val == 8'h01)
        else $error("read during assertion did not restart at one");
    sat_c: cover property (@(posedge sys_clk) disable iff (!rst_b) s.units == 8'hFF);
endmodule // tapc_timer

// ==== src/tapc_pwm.sv ====
// one fan drive output with low frequency choices and one high frequency
`timescale 1ns/100ps
module tapc_pwm import tapc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // setting
    input wire logic [7:0] duty,
    input wire logic [2:0] freq_sel,
    // drive
    output logic pwm
);
    tapc_pwm_t s, nxt; // state and next state
    logic [15:0] lim; // prescale end value

    // prescaler steps the 256 slot duty counter
    always_comb begin
        nxt = s;
        if (freq_sel == PWM_HIGH_SEL) begin
            lim = 16'h0000; // high frequency, no prescale
        end else begin
            lim = (PWM_LOW_BASE << freq_sel) - 16'h0001; // low choices
        end
        if (s.pre >= lim) begin
            nxt.pre = 16'h0000;
            nxt.cnt = s.cnt + 8'h01;
        end else begin
            nxt.pre = s.pre + 16'h0001;
        end
        nxt.out = (duty == DUTY_FULL) || (s.cnt < duty);
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= nxt;
        end
    end

    assign pwm = s.out;

    full_duty_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        duty == DUTY_FULL |=> pwm)
        else $error("full duty did not hold drive high");
endmodule // tapc_pwm

// ==== verif/tapc_far_end.sv ====
// far side model: processor hot source sharing the open drain alarm line
`timescale 1ns/100ps
module tapc_far_end (
    // clock
    input wire logic sys_clk,
    // command from the bench
    input wire logic hot_req,
    // open drain pull, low while pulling
    output logic pull_b
);
    logic pull_r = 1'b1; // released at time zero so the pull-up wins
    // only ever pulls low or lets go, never drives high
    always @(posedge sys_clk) begin
        pull_r <= ~hot_req;
    end
    assign pull_b = pull_r;
endmodule // tapc_far_end

// ==== verif/tapc_top_tb.sv ====
// testbench: register sequences, shared pin traffic and fan override checks
`timescale 1ns/100ps
module tapc_top_tb import tapc_pkg::*;;
    // stimulus
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic mon_upd = 1'b0;
    logic twos_mode = 1'b0;
    logic hot_req = 1'b0;
    tapc_temp_t [2:0] temps = '0;
    logic [2:0][7:0] duty_req = '0;
    // observed
    logic [7:0] reg_rdata;
    logic alarm_pin_o;
    logic alarm_pin_oe_b;
    logic [2:0][7:0] duty_eff;
    logic [2:0] fan_drive;
    logic fourth_speed_sense_input;
    logic smb_alert_req;
    logic timer_limit_flag;
    logic pull_b;
    logic alarm_wire;
    // bookkeeping
    int err_total = 0;
    int checks = 0;
    int n = 0;
    logic [7:0] rv;
    logic [7:0] ra [0:8] = '{8'h6A, 8'h6B, 8'h6C, 8'h75, 8'h78, 8'h7C, 8'h7D, 8'h7A, 8'h33};
    logic [7:0] re [0:8] = '{8'h64, 8'h64, 8'h64, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    // 4 ns clock
    always #2 sys_clk = ~sys_clk;
    // pulled-up line: low if either party pulls
    assign alarm_wire = ((alarm_pin_oe_b === 1'b0 && alarm_pin_o === 1'b0)
        || pull_b === 1'b0) ? 1'b0 : 1'b1;
    // block under test, short timer step
    tapc_top #(.TIMER_LSB_CYC(8)) i_tapc_top (.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .temps(temps), .mon_upd(mon_upd), .twos_mode(twos_mode),
        .duty_req(duty_req), .alarm_pin_i(alarm_wire), .alarm_pin_o(alarm_pin_o),
        .alarm_pin_oe_b(alarm_pin_oe_b), .duty_eff(duty_eff), .fan_drive(fan_drive),
        .fourth_speed_sense_input(fourth_speed_sense_input),
        .smb_alert_req(smb_alert_req), .timer_limit_flag(timer_limit_flag));
    // far side on the shared line
    tapc_far_end i_tapc_far_end (.sys_clk(sys_clk), .hot_req(hot_req), .pull_b(pull_b));
    // byte compare
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // bit compare
    task automatic cmp1(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    // wait falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    // one read strobe, data one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // monitoring cycle end pulse, then let the drive settle
    task automatic mon();
        @(negedge sys_clk);
        mon_upd = 1'b1;
        @(negedge sys_clk);
        mon_upd = 1'b0;
        cyc(3);
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end
    // main sequence
    initial begin
        cyc(16);
        rst_b = 1'b1;
        cmp1("oe_b rst", 1'b1, alarm_pin_oe_b);
        cmp1("pin level", 1'b0, alarm_pin_o);
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], rv);
            cmp8("reset value", re[i], rv);
        end
        wr(8'h6A, 8'h11);
        wr(8'h6B, 8'h22);
        wr(8'h6C, 8'h33);
        for (int i = 0; i < 3; i++) begin
            rd(8'h6A + 8'(i), rv);
            cmp8("limit", 8'h11 * 8'(i + 1), rv);
        end
        // speed sense role: pin passes through, no timing
        hot_req = 1'b1;
        cyc(3);
        cmp1("sense sync", 1'b1, fourth_speed_sense_input);
        cyc(3);
        cmp1("speed sense", 1'b0, fourth_speed_sense_input);
        hot_req = 1'b0;
        cyc(4);
        rd(8'h79, rv);
        cmp8("timer off", 8'h00, rv);
        // alarm role selected but enable clear
        wr(8'h7D, 8'h00);
        hot_req = 1'b1;
        cyc(40);
        hot_req = 1'b0;
        cyc(4);
        rd(8'h79, rv);
        cmp8("timer no enable", 8'h00, rv);
        cmp1("sense idle", 1'b1, fourth_speed_sense_input);
        // enabled: short assertion marks bit 0
        wr(8'h78, 8'h02);
        hot_req = 1'b1;
        cyc(4);
        hot_req = 1'b0;
        cyc(4);
        rd(8'h79, rv);
        cmp8("first assert", 8'h01, rv);
        cmp1("flag zero lim", 1'b1, timer_limit_flag);
        cmp1("alert", 1'b1, smb_alert_req);
        // long external assertion saturates
        hot_req = 1'b1;
        cyc(3000);
        rd(8'h79, rv);
        cmp8("saturate", 8'hFF, rv);
        wr(8'h75, 8'h20);
        cyc(2);
        cmp1("alert masked", 1'b0, smb_alert_req);
        cmp1("flag masked", 1'b1, timer_limit_flag);
        hot_req = 1'b0;
        cyc(4);
        rd(8'h79, rv);
        rd(8'h79, rv);
        cmp8("clear on read", 8'h00, rv);
        rd(8'h42, rv);
        cmp1("status bit", 1'b1, rv[5]);
        cyc(2);
        cmp1("flag cleared", 1'b0, timer_limit_flag);
        // output drive: remote 1 a quarter degree over, local over but not a source
        wr(8'h6A, 8'h50);
        wr(8'h7C, 8'h20);
        temps[0].whole = 8'h50;
        temps[0].frac = 2'h1;
        temps[1].whole = 8'h60;
        mon();
        cmp1("drive low", 1'b0, alarm_pin_oe_b);
        temps[0].frac = 2'h0;
        cyc(20);
        cmp1("held low", 1'b0, alarm_pin_oe_b);
        mon();
        cmp1("released", 1'b1, alarm_pin_oe_b);
        temps[0].whole = 8'h51;
        wr(8'h6A, 8'h00);
        mon();
        cmp1("limit off", 1'b1, alarm_pin_oe_b);
        // twos complement readings against a twos complement limit
        twos_mode = 1'b1;
        wr(8'h6A, 8'h10);
        temps[0].whole = 8'h10;
        temps[0].frac = 2'h1;
        mon();
        cmp1("twos drive", 1'b0, alarm_pin_oe_b);
        temps[0].whole = 8'hF0;
        mon();
        cmp1("twos negative", 1'b1, alarm_pin_oe_b);
        temps[0].whole = 8'h81;
        wr(8'h6A, 8'h80);
        mon();
        cmp1("twos limit off", 1'b1, alarm_pin_oe_b);
        twos_mode = 1'b0;
        wr(8'h6A, 8'h50);
        wr(8'h7C, 8'h00);
        mon();
        cmp1("input only", 1'b1, alarm_pin_oe_b);
        // full speed override, third fan stopped
        duty_req = {8'h00, 8'h40, 8'h30};
        wr(8'h78, 8'h06);
        hot_req = 1'b1;
        cyc(8);
        cmp8("full_speed_override fan1", DUTY_FULL, duty_eff[0]);
        cmp8("full_speed_override fan2", DUTY_FULL, duty_eff[1]);
        cmp8("stopped fan", 8'h00, duty_eff[2]);
        cmp1("drive full", 1'b1, fan_drive[0]);
        cmp1("drive stopped", 1'b0, fan_drive[2]);
        hot_req = 1'b0;
        cyc(8);
        cmp8("full_speed_override end", 8'h30, duty_eff[0]);
        wr(8'h78, 8'h02);
        hot_req = 1'b1;
        cyc(8);
        cmp8("no full_speed_override", 8'h40, duty_eff[1]);
        hot_req = 1'b0;
        cyc(4);
        // high drive frequency: a quarter duty is high 64 of every 256 clocks
        wr(8'h5F, 8'h07);
        cyc(4);
        repeat (256) begin
            cyc(1);
            if (fan_drive[1] === 1'b1) begin
                n++;
            end
        end
        cmp8("high freq duty", 8'h40, 8'(n));
        wrap_up();
    end
endmodule // tapc_top_tb
